// ===== omcc_defs.vh
// Constants for the operating-mode clock controller.
// Included by omcc_top.v and omcc_ready_timer.v.
`ifndef OMCC_DEFS_VH
`define OMCC_DEFS_VH
`define OMCC_ADDR_MODE      1'h0
`define OMCC_ADDR_RSTF      1'h1
`define OMCC_MODE_FCS       0
`define OMCC_MODE_IDLE      1
`define OMCC_MODE_FRDY      2
`define OMCC_MODE_SRDY      3
`define OMCC_MODE_QWE       4
`define OMCC_MODE_DIV_LO    5
`define OMCC_RSTF_WDR       0
`define OMCC_RSTF_THR       1
`define OMCC_RSTF_UVR       2
`define OMCC_RSTF_KEEP      7
`define OMCC_MODE_RESET     8'h01
`define OMCC_XTAL_SETTLE    8'd128
`define OMCC_IRC_SETTLE     8'd16
`define OMCC_SUB_WAKE       8'd2
`define OMCC_OSC_XTAL       2'h0
`define OMCC_OSC_IRC        2'h1
`endif

// ===== omcc_ready_timer.v
// Oscillator settle counter: counts ticks after start, then reports ready.
// Assumes tick is a one-cycle pulse of the oscillator being timed.
`timescale 1ns/1ns
`include "omcc_defs.vh"
module omcc_ready_timer (
	input  wire       clock,
	input  wire       rstn,
	input  wire       run,
	input  wire       tick,
	input  wire [7:0] limit,
	output reg        ready_q
);
	reg [7:0] cnt_q;
	always @(posedge clock) begin
		if (!rstn || !run) begin
			cnt_q   <= 8'h00;
			ready_q <= 1'b0;
		end else if (tick && !ready_q) begin
			if (cnt_q + 8'd1 >= limit) begin
				ready_q <= 1'b1;
			end
			cnt_q <= cnt_q + 8'd1;
		end
	end
endmodule

// ===== omcc_top.v
// Operating-mode and system-clock controller: mode register, reset flags,
// halt decode and wake-up sequencing. Assumes one clock and ticks from osc.
`timescale 1ns/1ns
`include "omcc_defs.vh"
module omcc_top (
	input  wire       clock,
	input  wire       rstn,
	input  wire       addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata_q,
	input  wire       halt,
	input  wire       wake,
	input  wire       watchdog_on,
	input  wire [1:0] fast_osc_type,
	input  wire       slow_is_crystal,
	input  wire       fast_tick,
	input  wire       sub_tick,
	input  wire       uvr_event,
	input  wire       thr_invalid,
	input  wire       wdr_event,
	output wire       core_run,
	output wire       sys_clk_en,
	output wire       sys_from_sub,
	output wire       fast_osc_en,
	output wire       fast_div_clk_en,
	output wire       sub_osc_en,
	output wire [2:0] clk_div_sel,
	output wire       sel_undivided
);
	localparam RUN   = 6'b000001;
	localparam DEEP  = 6'b000010;
	localparam WDS   = 6'b000100;
	localparam RIDLE = 6'b001000;
	localparam FIDLE = 6'b010000;
	localparam WAKE  = 6'b100000;

	reg [5:0] st_q;
	reg [5:0] st_d;
	reg [7:0] mode_q;
	reg [2:0] flags_q;
	reg       keep_q;
	reg       quick_q;
	reg       quick_d;
	reg       sub_cnt_q;
	reg       sub_done_q;

	wire fast_rdy;
	wire slow_rdy;
	wire slow_sel;
	wire wr_mode = wr && (addr == `OMCC_ADDR_MODE);
	wire wr_rstf = wr && (addr == `OMCC_ADDR_RSTF);

	// Slow source picked: select bit low and divider field 000 or 001
	assign slow_sel = !mode_q[`OMCC_MODE_FCS] && (mode_q[7:6] == 2'b00);
	assign clk_div_sel = mode_q[7:5];
	assign sel_undivided = mode_q[`OMCC_MODE_FCS];

	// Fast oscillator off while slow clock in use or sleeping without it
	assign fast_osc_en = !slow_sel && ((st_q == RUN) || (st_q == FIDLE) ||
		(st_q == WAKE));
	assign fast_div_clk_en = fast_osc_en && fast_rdy;
	assign sub_osc_en = (st_q != DEEP) || watchdog_on;

	always @* begin
		st_d = st_q;
		quick_d = quick_q;
		case (st_q)
			RUN: begin
				if (halt) begin
					if (mode_q[`OMCC_MODE_IDLE]) begin
						st_d = keep_q ? FIDLE : RIDLE;
					end else begin
						st_d = watchdog_on ? WDS : DEEP;
					end
				end
			end
			DEEP, WDS, RIDLE: begin
				if (wake) begin
					st_d = WAKE;
					// Quick wake needs crystal and a running auxiliary clock
					quick_d = (st_q != DEEP) && mode_q[`OMCC_MODE_QWE] &&
						(fast_osc_type == `OMCC_OSC_XTAL) && !slow_sel;
				end
			end
			FIDLE: begin
				if (wake) begin
					st_d = RUN;
				end
			end
			WAKE: begin
				if (quick_q ? sub_done_q : (slow_sel ? slow_rdy : fast_rdy)) begin
					st_d = RUN;
					quick_d = 1'b0;
				end
			end
			default: st_d = RUN;
		endcase
	end

	always @(posedge clock) begin
		if (!rstn) begin
			st_q <= RUN;
			quick_q <= 1'b0;
			sub_cnt_q <= 1'b0;
			sub_done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			quick_q <= quick_d;
			if (st_q != WAKE) begin
				sub_cnt_q <= 1'b0;
				sub_done_q <= 1'b0;
			end else if (sub_tick && !sub_done_q) begin
				sub_cnt_q <= 1'b1;
				sub_done_q <= sub_cnt_q;
			end
		end
	end

	// Quick wake selects the auxiliary clock until crystal settles or quick_q clears on leaving WAKE
	assign sys_from_sub = (quick_q && !fast_rdy) || slow_sel;
	assign core_run = (st_q == RUN);
	assign sys_clk_en = (st_q == RUN) || (st_q == FIDLE) ||
		(sys_from_sub && (st_q == RUN));

	// Fast timer restarts whenever the oscillator is off
	omcc_ready_timer u_fast (
		.clock   (clock),
		.rstn    (rstn),
		.run     (fast_osc_en),
		.tick    (fast_tick),
		.limit   ((fast_osc_type == `OMCC_OSC_XTAL) ? `OMCC_XTAL_SETTLE :
			((fast_osc_type == `OMCC_OSC_IRC) ? `OMCC_IRC_SETTLE : `OMCC_SUB_WAKE)),
		.ready_q (fast_rdy)
	);

	omcc_ready_timer u_slow (
		.clock   (clock),
		.rstn    (rstn),
		.run     (sub_osc_en),
		.tick    (sub_tick),
		.limit   (slow_is_crystal ? `OMCC_XTAL_SETTLE : `OMCC_SUB_WAKE),
		.ready_q (slow_rdy)
	);

	always @(posedge clock) begin
		if (!rstn) begin
			mode_q <= `OMCC_MODE_RESET;
			keep_q <= 1'b0;
		end else begin
			if (wr_mode) begin
				// Ready bits are status only; writes to them are dropped
				mode_q <= {wdata[7:4], 2'b00, wdata[1:0]};
			end
			if (wr_rstf) begin
				keep_q <= wdata[`OMCC_RSTF_KEEP];
			end
		end
	end

	// Flags are not reset by rstn: they record what caused the reset
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_flag
			wire ev = (i == `OMCC_RSTF_WDR) ? wdr_event :
				((i == `OMCC_RSTF_THR) ? thr_invalid : uvr_event);
			always @(posedge clock) begin
				if (ev) begin
					flags_q[i] <= 1'b1;
				end else if (wr_rstf && !wdata[i]) begin
					flags_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Power-up zero for all three flags
	initial flags_q = 3'b000;

	always @(posedge clock) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else if (rd) begin
			if (addr == `OMCC_ADDR_MODE) begin
				rdata_q <= {mode_q[7:4], slow_rdy, fast_rdy, mode_q[1:0]};
			end else begin
				rdata_q <= {keep_q, 4'h0, flags_q};
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
endmodule

// ===== omcc_chk.sv
// Port checker for the operating-mode clock controller.
// Assumes it is bound into omcc_top and sees only its ports.
`timescale 1ns/1ns
module omcc_chk (
	input wire       clock, rstn, addr, wr, rd, halt, uvr_event, thr_invalid, wdr_event,
	input wire       core_run, sys_clk_en, fast_osc_en, fast_div_clk_en, sel_undivided,
	input wire [7:0] wdata, rdata_q,
	input wire [2:0] clk_div_sel
);
	reg idle_q, keep_q;
	// Shadow of the two halt-mode bits, from the write port alone
	always @(posedge clock) begin
		if (wr && addr) keep_q <= wdata[7];
		if (wr && !addr) idle_q <= wdata[1];
		if (!rstn) {idle_q, keep_q} <= 2'h0;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_rd1; rd && addr && !wr; endsequence
	sequence s_mwr; wr && !addr; endsequence
	a_sel_undiv: assert property (s_mwr |=> sel_undivided == $past(wdata[0]))
		else $error("undivided select does not follow write");
	a_div_field: assert property (s_mwr |=> clk_div_sel == $past(wdata[7:5]))
		else $error("divider field does not follow write");
	a_unimpl_zero: assert property (s_rd1 |=> rdata_q[6:3] == 4'h0)
		else $error("unused flag bits read nonzero");
	a_uvr_set: assert property (uvr_event ##1 s_rd1 |=> rdata_q[2])
		else $error("undervoltage flag not set");
	a_thr_set: assert property (thr_invalid ##1 s_rd1 |=> rdata_q[1])
		else $error("threshold flag not set");
	a_wdr_set: assert property (wdr_event ##1 s_rd1 |=> rdata_q[0])
		else $error("watchdog flag not set");
	a_halt_idle: assert property (core_run && halt && idle_q |=>
		!core_run && sys_clk_en == keep_q) else $error("wrong idle variant on halt");
	a_halt_sleep: assert property (core_run && halt && !idle_q |=>
		!core_run && !sys_clk_en) else $error("sleep not entered on halt");
	a_fast_off: assert property (core_run && !sel_undivided &&
		clk_div_sel[2:1] == 2'h0 |-> !fast_osc_en) else $error("fast oscillator left on");
	a_div_stop: assert property (!fast_osc_en |-> !fast_div_clk_en)
		else $error("divided clocks run without fast oscillator");
endmodule
bind omcc_top omcc_chk chk (.*);

// ===== omcc_osc_model.sv
// Oscillator model: one tick pulse per oscillator cycle while enabled.
// Assumes enables come from the controller; a stopped oscillator gives no ticks.
`timescale 1ns/1ns
module omcc_osc_model (
	input  wire clock, rstn, fast_en, sub_en,
	output reg  fast_tick, sub_tick
);
	reg [2:0] cnt_q;
	initial {fast_tick, sub_tick} = 2'h0;
	// Fast ticks every 2 cycles, auxiliary every 8
	always @(posedge clock) begin
		cnt_q <= rstn ? cnt_q + 3'h1 : 3'h0;
		fast_tick <= rstn && fast_en && cnt_q[0];
		sub_tick <= rstn && sub_en && cnt_q == 3'h7;
	end
endmodule

// ===== tb_operating_mode_clock_control.sv
// Testbench for the operating-mode clock controller.
// Assumes omcc_top, the oscillator model and the bound checker are compiled.
`timescale 1ns/1ns
module tb_operating_mode_clock_control;
	reg          clock = 0, rstn = 0, addr = 0, wr = 0, rd = 0, rd_d = 0, watchdog_on = 0;
	reg  [7:0]   wdata = 8'h00, r;
	reg  [4:0]   pl = 5'h00;
	wire [7:0]   rdata_q;
	wire [2:0]   clk_div_sel;
	wire         core_run, sys_clk_en, sys_from_sub, fast_osc_en, fast_div_clk_en;
	wire         sub_osc_en, sel_undivided, fast_tick, sub_tick;
	wire         halt, wake, uvr_event, thr_invalid, wdr_event;
	logic [15:0] q[$];
	logic [15:0] e;
	logic [12:0] t;
	logic [12:0] tbl [4] = '{13'h0220, 13'h0229, 13'h0261, 13'h0073};
	int          failures = 0, checked = 0, seed = 32'h2c1f, k, w;
	assign {halt, wake, uvr_event, thr_invalid, wdr_event} = pl;
	always #4 clock = ~clock;
	omcc_top dut (.*, .fast_osc_type(2'h0), .slow_is_crystal(1'b0));
	omcc_osc_model osc (.clock, .rstn, .fast_en(fast_osc_en), .sub_en(sub_osc_en),
		.fast_tick, .sub_tick);
	task cmp(input logic [7:0] ex, got, m);
		checked++;
		if ((got & m) !== (ex & m)) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, ex);
		end
	endtask
	task close_out;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Trailing idle edge keeps back-to-back calls from double-driving a strobe
	task wr_reg(input logic a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock) wr <= 1'b0;
		@(posedge clock);
	endtask
	task rd_reg(input logic a, input logic [7:0] m, ex);
		addr <= a;
		rd <= 1'b1;
		q.push_back({m, ex});
		@(posedge clock) rd <= 1'b0;
		@(posedge clock);
	endtask
	task pulse(input logic [4:0] p);
		pl <= p;
		@(posedge clock) pl <= 5'h00;
	endtask
	always @(posedge clock) rd_d <= rd;
	always @(negedge clock) if (rd_d) begin
		e = q.pop_front();
		cmp(e[7:0], rdata_q, e[15:8]);
	end
	initial begin
		#200000;
		failures++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		repeat (300) @(posedge clock);
		wr_reg(1'b0, 8'h01);
		rd_reg(1'b0, 8'hf7, 8'h05);
		for (k = 0; k < 5; k++) begin
			r = (k == 0) ? 8'h00 : 8'($random(seed));
			wr_reg(1'b0, r);
			rd_reg(1'b0, 8'hf3, r);
		end
		wr_reg(1'b0, 8'h01);
		for (k = 0; k < 3; k++) begin
			pulse(5'h01 << k);
			rd_reg(1'b1, 8'hff, 8'h01 << k);
			wr_reg(1'b1, 8'hf8 | (8'h01 << k));
			rd_reg(1'b1, 8'hff, 8'h80 | (8'h01 << k));
			wr_reg(1'b1, 8'h00);
		end
		// Deep stop, watchdog stop, reduced idle, full idle
		for (k = 0; k < 4; k++) begin
			t = tbl[k];
			watchdog_on <= t[3];
			wr_reg(1'b1, {t[4], 7'h00});
			wr_reg(1'b0, t[12:5]);
			pulse(5'h10);
			repeat (2) @(posedge clock);
			cmp({6'h0, t[2:1]}, {6'h0, core_run, sys_clk_en}, 8'hff);
			pulse(5'h08);
			repeat (40) @(posedge clock);
			cmp({7'h0, t[0]}, {7'h0, core_run}, 8'hff);
			for (w = 0; w < 2000 && core_run !== 1'b1; w++) @(posedge clock);
			cmp(8'h01, {7'h0, core_run}, 8'hff);
		end
		close_out;
	end
endmodule
